/* logic/afws_status.v */
// fault and warning status registers, output shutdown and error pin of the amplifier
`timescale 1ns/1ns
`include "afws_consts.vh"

module afws_status (
    input wire sys_clk,
    input wire rst,
    // raw condition levels from the analog detectors
    input wire clock_fail_in,
    input wire supply_over_voltage_in,
    input wire supply_under_voltage_in,
    input wire thermal_shutdown_in,
    input wire left_current_limit_error_in,
    input wire right_current_limit_error_in,
    input wire left_current_limit_alert_in,
    input wire right_current_limit_alert_in,
    // die temperature in degrees C from on-clock sensor logic
    input wire [7:0] die_temp,
    // register port
    input wire [7:0] reg_addr,
    input wire reg_wr_en,
    input wire [7:0] reg_wr_data,
    input wire reg_rd_en,
    output reg [7:0] reg_rd_data_r,
    // pins
    output reg power_hiz_r,
    output reg error_indicator_n_r
);

    // index of each condition in the synchroniser vector
    localparam IDX_CLK = 0;
    localparam IDX_OV = 1;
    localparam IDX_UV = 2;
    localparam IDX_TSD = 3;
    localparam IDX_LERR = 4;
    localparam IDX_RERR = 5;
    localparam IDX_LALT = 6;
    localparam IDX_RALT = 7;

    wire [7:0] raw_cond;
    wire [7:0] live_cond;

    // temperature comparison used for every heat level
    function at_or_above;
        input [7:0] temp;
        input [7:0] limit;
        begin
            at_or_above = (temp >= limit);
        end
    endfunction

    // 8-bit register read with reserved bits forced low
    function [7:0] place_bits;
        input [7:0] value;
        input [7:0] used;
        begin
            place_bits = value & used;
        end
    endfunction

    assign raw_cond = {right_current_limit_alert_in, left_current_limit_alert_in,
                       right_current_limit_error_in, left_current_limit_error_in,
                       thermal_shutdown_in, supply_under_voltage_in,
                       supply_over_voltage_in, clock_fail_in};

    // analog levels come from outside the clock domain
    afws_sync #(
        .WIDTH(8)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(raw_cond),
        .sync_out(live_cond)
    );

    // sticky flags
    reg clock_fail_flag_r;
    reg supply_over_voltage_flag_r;
    reg supply_under_voltage_flag_r;
    reg thermal_shutdown_flag_r;
    reg left_current_limit_error_flag_r;
    reg right_current_limit_error_flag_r;
    reg left_current_limit_alert_flag_r;
    reg right_current_limit_alert_flag_r;
    reg heat_alert_level_one_r;
    reg heat_alert_level_two_r;
    reg heat_alert_level_three_r;
    reg heat_alert_level_four_r;

    // report mask bits
    reg [2:0] report_mask_r;

    wire heat_alert_mask;
    wire mask_cbc_err;
    wire mask_cbc_alert;
    wire clear_pulse;
    wire mask_write;
    wire heat_l1_now;
    wire heat_l2_now;
    wire heat_l3_now;
    wire heat_l4_now;
    wire serious_live;
    wire serious_flags;
    wire unmasked_other;

    assign heat_alert_mask = report_mask_r[`AFWS_BIT_HEAT_ALERT_MASK];
    assign mask_cbc_err = report_mask_r[`AFWS_BIT_MASK_CBC_ERR];
    assign mask_cbc_alert = report_mask_r[`AFWS_BIT_MASK_CBC_ALERT];

    // fault clear write decode
    // clear bit strobe
    assign clear_pulse = reg_wr_en && (reg_addr == `AFWS_OFS_FAULT_CLEAR)
                         && reg_wr_data[`AFWS_BIT_FAULT_CLEAR];
    // writes to the status offsets decode to nothing, so they are dropped
    assign mask_write = reg_wr_en && (reg_addr == `AFWS_OFS_REPORT_MASK);

    // heat levels compared against die temperature
    // all four heat thresholds, highest first
    assign heat_l4_now = at_or_above(die_temp, `AFWS_HEAT_L4_DEG);
    assign heat_l3_now = at_or_above(die_temp, `AFWS_HEAT_L3_DEG);
    assign heat_l2_now = at_or_above(die_temp, `AFWS_HEAT_L2_DEG);
    assign heat_l1_now = at_or_above(die_temp, `AFWS_HEAT_L1_DEG);

    // power stage comes back on its own once the condition clears; flags and the error pin wait for the host
    // live serious conditions; shutdown tracks them, not the flags
    // recovery follows the live clock level
    // recovery follows the live supply and thermal levels
    assign serious_live = live_cond[IDX_CLK] | live_cond[IDX_OV] | live_cond[IDX_UV] | live_cond[IDX_TSD];

    // sticky serious flags always reach the pin
    // serious faults reported
    assign serious_flags = clock_fail_flag_r | supply_over_voltage_flag_r
                           | supply_under_voltage_flag_r | thermal_shutdown_flag_r;

    // maskable flags
    // current-limit error, current-limit alert and heat alert mask gates
    assign unmasked_other = ((left_current_limit_error_flag_r | right_current_limit_error_flag_r) & ~mask_cbc_err)
                            | ((left_current_limit_alert_flag_r | right_current_limit_alert_flag_r) & ~mask_cbc_alert)
                            | ((heat_alert_level_one_r | heat_alert_level_two_r | heat_alert_level_three_r
                                | heat_alert_level_four_r) & ~heat_alert_mask);

    // supply and clock flags; a new event wins over a clear in the same cycle
    // hold until cleared
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clock_fail_flag_r <= 1'b0;
            supply_over_voltage_flag_r <= 1'b0;
            supply_under_voltage_flag_r <= 1'b0;
        end else begin
            clock_fail_flag_r <= live_cond[IDX_CLK] | (clock_fail_flag_r & ~clear_pulse);
            supply_over_voltage_flag_r <= live_cond[IDX_OV] | (supply_over_voltage_flag_r & ~clear_pulse);
            supply_under_voltage_flag_r <= live_cond[IDX_UV] | (supply_under_voltage_flag_r & ~clear_pulse);
        end
    end

    // thermal shutdown and current-limit error flags
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            thermal_shutdown_flag_r <= 1'b0;
            left_current_limit_error_flag_r <= 1'b0;
            right_current_limit_error_flag_r <= 1'b0;
        end else begin
            thermal_shutdown_flag_r <= live_cond[IDX_TSD] | (thermal_shutdown_flag_r & ~clear_pulse);
            left_current_limit_error_flag_r <= live_cond[IDX_LERR]
                                               | (left_current_limit_error_flag_r & ~clear_pulse);
            right_current_limit_error_flag_r <= live_cond[IDX_RERR]
                                                | (right_current_limit_error_flag_r & ~clear_pulse);
        end
    end

    // alert flags
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            left_current_limit_alert_flag_r <= 1'b0;
            right_current_limit_alert_flag_r <= 1'b0;
            heat_alert_level_one_r <= 1'b0;
            heat_alert_level_two_r <= 1'b0;
            heat_alert_level_three_r <= 1'b0;
            heat_alert_level_four_r <= 1'b0;
        end else begin
            left_current_limit_alert_flag_r <= live_cond[IDX_LALT]
                                               | (left_current_limit_alert_flag_r & ~clear_pulse);
            right_current_limit_alert_flag_r <= live_cond[IDX_RALT]
                                                | (right_current_limit_alert_flag_r & ~clear_pulse);
            heat_alert_level_four_r <= heat_l4_now | (heat_alert_level_four_r & ~clear_pulse);
            heat_alert_level_three_r <= heat_l3_now | (heat_alert_level_three_r & ~clear_pulse);
            heat_alert_level_two_r <= heat_l2_now | (heat_alert_level_two_r & ~clear_pulse);
            heat_alert_level_one_r <= heat_l1_now | (heat_alert_level_one_r & ~clear_pulse);
        end
    end

    // report mask register, software written
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            report_mask_r <= `AFWS_RST_MASK;
        end else if (mask_write) begin
            report_mask_r <= reg_wr_data[2:0];
        end
    end

    // status words assembled from the flags
    reg [7:0] supply_clock_word;
    reg [7:0] thermal_limit_word;
    reg [7:0] alert_word;

    always @* begin
        supply_clock_word = `AFWS_RST_STATUS;
        supply_clock_word[`AFWS_BIT_SUPPLY_UV] = supply_under_voltage_flag_r;
        supply_clock_word[`AFWS_BIT_SUPPLY_OV] = supply_over_voltage_flag_r;
        supply_clock_word[`AFWS_BIT_CLOCK_FAIL] = clock_fail_flag_r;
        thermal_limit_word = `AFWS_RST_STATUS;
        thermal_limit_word[`AFWS_BIT_THERMAL_SD] = thermal_shutdown_flag_r;
        thermal_limit_word[`AFWS_BIT_LEFT_CBC_ERR] = left_current_limit_error_flag_r;
        thermal_limit_word[`AFWS_BIT_RIGHT_CBC_ERR] = right_current_limit_error_flag_r;
        alert_word = `AFWS_RST_STATUS;
        alert_word[`AFWS_BIT_HEAT_L1] = heat_alert_level_one_r;
        alert_word[`AFWS_BIT_HEAT_L2] = heat_alert_level_two_r;
        alert_word[`AFWS_BIT_HEAT_L3] = heat_alert_level_three_r;
        alert_word[`AFWS_BIT_HEAT_L4] = heat_alert_level_four_r;
        alert_word[`AFWS_BIT_RIGHT_CBC_ALERT] = right_current_limit_alert_flag_r;
        alert_word[`AFWS_BIT_LEFT_CBC_ALERT] = left_current_limit_alert_flag_r;
    end

    // read mux; unmapped and write-only addresses read zero
    reg [7:0] rd_nxt;

    always @* begin
        rd_nxt = 8'h00;
        case (reg_addr)
            // upper bits of the supply/clock word are not modelled and read zero
            `AFWS_OFS_SUPPLY_CLOCK: begin
                rd_nxt = place_bits(supply_clock_word, 8'h07);
            end
            `AFWS_OFS_THERMAL_LIMIT: begin
                rd_nxt = place_bits(thermal_limit_word, 8'h07);
            end
            `AFWS_OFS_ALERT: begin
                rd_nxt = place_bits(alert_word, 8'h3F);
            end
            `AFWS_OFS_REPORT_MASK: begin
                rd_nxt = {5'h00, report_mask_r};
            end
            default: begin
                rd_nxt = 8'h00;
            end
        endcase
    end

    // read data register, held between reads
    // a write never disturbs the last word read
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rd_data_r <= 8'h00;
        end else if (reg_rd_en) begin
            reg_rd_data_r <= rd_nxt;
        end
    end

    // power stage shutdown and error pin
    // the pin uses the sticky flags so a short fault is never missed
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            power_hiz_r <= 1'b0;
            error_indicator_n_r <= 1'b1;
        end else begin
            power_hiz_r <= serious_live;
            // pin low while any unmasked flag set
            error_indicator_n_r <= ~(serious_flags | unmasked_other);
        end
    end

endmodule

/* logic/afws_sync.v */
// two-flop synchroniser for a group of independent level inputs
`timescale 1ns/1ns

module afws_sync #(
    parameter WIDTH = 8
) (
    input wire sys_clk,
    input wire rst,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] stable_r;

    // first stage feeds only the second stage
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_r <= {WIDTH{1'b0}};
            stable_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= async_in;
            stable_r <= meta_r;
        end
    end

    assign sync_out = stable_r;

endmodule

/* shared/afws_consts.vh */
// register offsets, field positions and reset values of the amplifier fault/warning status block
`ifndef AFWS_CONSTS_VH
`define AFWS_CONSTS_VH

// register offsets on the control port
`define AFWS_OFS_SUPPLY_CLOCK 8'h71
`define AFWS_OFS_THERMAL_LIMIT 8'h72
`define AFWS_OFS_ALERT 8'h73
`define AFWS_OFS_REPORT_MASK 8'h75
`define AFWS_OFS_FAULT_CLEAR 8'h78

// supply and clock error status fields
`define AFWS_BIT_SUPPLY_UV 0
`define AFWS_BIT_SUPPLY_OV 1
`define AFWS_BIT_CLOCK_FAIL 2

// thermal and current-limit error status fields
`define AFWS_BIT_THERMAL_SD 0
`define AFWS_BIT_LEFT_CBC_ERR 1
`define AFWS_BIT_RIGHT_CBC_ERR 2

// alert status fields
`define AFWS_BIT_HEAT_L1 0
`define AFWS_BIT_HEAT_L2 1
`define AFWS_BIT_HEAT_L3 2
`define AFWS_BIT_HEAT_L4 3
`define AFWS_BIT_RIGHT_CBC_ALERT 4
`define AFWS_BIT_LEFT_CBC_ALERT 5

// report mask fields
`define AFWS_BIT_MASK_CBC_ERR 0
`define AFWS_BIT_MASK_CBC_ALERT 1
`define AFWS_BIT_HEAT_ALERT_MASK 2

// fault clear field
`define AFWS_BIT_FAULT_CLEAR 7

// reset values
`define AFWS_RST_STATUS 8'h00
`define AFWS_RST_MASK 3'h0

// heat alert thresholds in degrees C: 112, 122, 134, 146
`define AFWS_HEAT_L1_DEG 8'h70
`define AFWS_HEAT_L2_DEG 8'h7A
`define AFWS_HEAT_L3_DEG 8'h86
`define AFWS_HEAT_L4_DEG 8'h92

`endif

/* verification/afws_host.sv */
// host model driving the register port of the status block
`timescale 1ns/1ns
module afws_host (
    input wire sys_clk,
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wr_data,
    output logic reg_rd_en,
    input wire [7:0] reg_rd_data_r
);
    // idle port at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
        reg_addr <= ~a;
        reg_wr_data <= ~d;
    endtask
    // read strobe, data taken once registered
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        @(posedge sys_clk);
        d = reg_rd_data_r;
    endtask
endmodule

/* verification/afws_status_sva.sv */
// port assertions of the fault and warning status block
`timescale 1ns/1ns
module afws_status_sva (
    input wire sys_clk,
    input wire rst,
    input wire clock_fail_in,
    input wire supply_over_voltage_in,
    input wire supply_under_voltage_in,
    input wire thermal_shutdown_in,
    input wire [7:0] die_temp,
    input wire [7:0] reg_addr,
    input wire reg_rd_en,
    input wire [7:0] reg_rd_data_r,
    input wire power_hiz_r,
    input wire error_indicator_n_r
);
    // any condition that silences the power stage
    wire serious = clock_fail_in | supply_over_voltage_in | supply_under_voltage_in | thermal_shutdown_in;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_hiz_on_fault: assert property (serious [*4] |=> power_hiz_r)
        else $error("outputs not high impedance during fault");
    a_hiz_recovers: assert property ((!serious) [*4] |=> !power_hiz_r)
        else $error("outputs still high impedance after recovery");
    a_pin_on_fault: assert property ($rose(power_hiz_r) |=> !error_indicator_n_r)
        else $error("error pin not driven on fault");
    a_thermal_flag: assert property (thermal_shutdown_in [*4] ##0 (reg_rd_en && reg_addr == 8'h72) |=> reg_rd_data_r[0])
        else $error("thermal shutdown flag not read back");
    a_clock_flag: assert property (clock_fail_in [*4] ##0 (reg_rd_en && reg_addr == 8'h71) |=> reg_rd_data_r[2])
        else $error("clock failure flag not read back");
    a_heat_levels: assert property ((die_temp >= 8'h92) [*3] ##0 (reg_rd_en && reg_addr == 8'h73) |=> reg_rd_data_r[3:0] == 4'hF)
        else $error("heat alert levels not all set");
    a_limit_reserved: assert property (reg_rd_en && reg_addr == 8'h72 |=> reg_rd_data_r[7:3] == 5'h00)
        else $error("reserved thermal status bits not zero");
    a_alert_reserved: assert property (reg_rd_en && reg_addr == 8'h73 |=> reg_rd_data_r[7:6] == 2'h0)
        else $error("reserved alert bits not zero");
    a_clear_wo: assert property (reg_rd_en && reg_addr == 8'h78 |=> reg_rd_data_r == 8'h00)
        else $error("fault clear register readable");
    a_read_holds: assert property (!reg_rd_en |=> $stable(reg_rd_data_r))
        else $error("read data changed without a read");
endmodule

/* verification/test_amp_fault_warning_status.sv */
// self-checking bench for the fault and warning status block
`timescale 1ns/1ns
module test_amp_fault_warning_status;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] cond = 8'h00;
    logic [7:0] die_temp = 8'h00;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data_r;
    logic reg_wr_en, reg_rd_en, power_hiz_r, error_indicator_n_r;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    logic [7:0] caddr [0:7] = '{8'h71, 8'h71, 8'h71, 8'h72, 8'h72, 8'h72, 8'h73, 8'h73};
    logic [7:0] cmask [0:7] = '{8'h04, 8'h02, 8'h01, 8'h01, 8'h02, 8'h04, 8'h20, 8'h10};
    logic [7:0] temps [0:5] = '{8'h6F, 8'h70, 8'h79, 8'h7A, 8'h86, 8'h92};
    logic [3:0] heat [0:5] = '{4'h0, 4'h1, 4'h1, 4'h3, 4'h7, 4'hF};

    afws_status afws_status_i (.sys_clk(sys_clk), .rst(rst), .clock_fail_in(cond[0]),
        .supply_over_voltage_in(cond[1]), .supply_under_voltage_in(cond[2]), .thermal_shutdown_in(cond[3]),
        .left_current_limit_error_in(cond[4]), .right_current_limit_error_in(cond[5]),
        .left_current_limit_alert_in(cond[6]), .right_current_limit_alert_in(cond[7]), .die_temp(die_temp),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
        .reg_rd_data_r(reg_rd_data_r), .power_hiz_r(power_hiz_r), .error_indicator_n_r(error_indicator_n_r));
    afws_host afws_host_i (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data_r(reg_rd_data_r));

    // clock generator
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    // verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // compare and count
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // read a register and compare
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        afws_host_i.rd(a, d);
        chk(what, exp, d);
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            results();
        end
    end
    // main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        afws_host_i.wr(8'h72, 8'hFF);
        foreach (caddr[i]) rdchk(caddr[i], 8'h00, "status reset");
        rdchk(8'h78, 8'h00, "clear reg");
        rdchk(8'h10, 8'h00, "unmapped");
        afws_host_i.wr(8'h75, 8'hFF);
        rdchk(8'h75, 8'h07, "mask reg");
        afws_host_i.wr(8'h75, 8'h00);
        chk("pin idle", 8'h01, {7'h0, error_indicator_n_r});
        $display("test map done");
        foreach (caddr[i]) begin
            cond <= 8'h01 << i;
            repeat (5) @(posedge sys_clk);
            rdchk(caddr[i], cmask[i], "flag set");
            afws_host_i.wr(8'h78, 8'h80);
            rdchk(caddr[i], cmask[i], "flag live");
            chk("hiz", {7'h0, i < 4}, {7'h0, power_hiz_r});
            chk("pin low", 8'h00, {7'h0, error_indicator_n_r});
            cond <= 8'h00;
            repeat (5) @(posedge sys_clk);
            chk("hiz gone", 8'h00, {7'h0, power_hiz_r});
            afws_host_i.wr(8'h78, 8'h7F);
            rdchk(caddr[i], cmask[i], "flag latched");
            afws_host_i.wr(8'h78, 8'h80);
            rdchk(caddr[i], 8'h00, "flag cleared");
            chk("pin high", 8'h01, {7'h0, error_indicator_n_r});
        end
        $display("test conditions done");
        foreach (temps[i]) begin
            die_temp <= temps[i];
            repeat (3) @(posedge sys_clk);
            rdchk(8'h73, {4'h0, heat[i]}, "heat level");
            die_temp <= 8'h00;
            afws_host_i.wr(8'h78, 8'h80);
        end
        $display("test heat levels done");
        afws_host_i.wr(8'h75, 8'h04);
        die_temp <= 8'h92;
        repeat (4) @(posedge sys_clk);
        chk("pin masked", 8'h01, {7'h0, error_indicator_n_r});
        afws_host_i.wr(8'h75, 8'h00);
        repeat (2) @(posedge sys_clk);
        chk("pin unmasked", 8'h00, {7'h0, error_indicator_n_r});
        die_temp <= 8'h00;
        afws_host_i.wr(8'h78, 8'h80);
        repeat (2) @(posedge sys_clk);
        chk("pin cleared", 8'h01, {7'h0, error_indicator_n_r});
        $display("test heat mask done");
        // current-limit masks keep those flags off the pin, flags still latch
        afws_host_i.wr(8'h75, 8'h03);
        cond <= 8'hF0;
        repeat (5) @(posedge sys_clk);
        chk("pin limit masked", 8'h01, {7'h0, error_indicator_n_r});
        chk("hiz limit", 8'h00, {7'h0, power_hiz_r});
        rdchk(8'h72, 8'h06, "limit errors");
        rdchk(8'h73, 8'h30, "limit alerts");
        afws_host_i.wr(8'h75, 8'h01);
        repeat (2) @(posedge sys_clk);
        chk("pin alert unmasked", 8'h00, {7'h0, error_indicator_n_r});
        cond <= 8'h00;
        repeat (3) @(posedge sys_clk);
        afws_host_i.wr(8'h78, 8'h80);
        afws_host_i.wr(8'h75, 8'h00);
        repeat (2) @(posedge sys_clk);
        chk("pin limit cleared", 8'h01, {7'h0, error_indicator_n_r});
        $display("test limit mask done");
        results();
    end
endmodule

bind afws_status afws_status_sva afws_status_sva_i (.sys_clk(sys_clk), .rst(rst), .clock_fail_in(clock_fail_in),
    .supply_over_voltage_in(supply_over_voltage_in), .supply_under_voltage_in(supply_under_voltage_in),
    .thermal_shutdown_in(thermal_shutdown_in), .die_temp(die_temp), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en),
    .reg_rd_data_r(reg_rd_data_r), .power_hiz_r(power_hiz_r), .error_indicator_n_r(error_indicator_n_r));
